/* hw/phy_mac_side.sv */
// PHY end: collision, carrier sense, reduced-pin and serial data cadence,
// receive elasticity buffer and the management frame engine.
// Assumes MDC/MDIO come from outside the mclk domain; line side on mclk.
// Contract
// - Half duplex: tx and rx together flag collision
// - 10 Mb transmit: collision after seven bits
// - Collision during receive reported at once
// - Heartbeat: ten-bit pulse one microsecond after packet
// - 10 Mb carrier needs squelch-qualified data
// - 100 Mb carrier: signal detect and two zeros
// - Half duplex: carrier also during own transmit
// - Full duplex: carrier only from receive
// - Carrier drops after end of packet
// - Reduced-pin: two bits per shared reference clock
// - Separate receive data valid output
// - 10 Mb reduced-pin: transfer every tenth clock
// - Buffer slip corrupts frame, sets bypass flags
// - Start threshold field selects 4-bit steps
// - Serial mode: one bit per 10 MHz clock
// - Management clock at most 25 MHz
// - Frames ignored until 32 ones seen
// - Frame: start, opcode, addresses, turnaround, data
// - Read turnaround: release, then zero, then data
// - Write turnaround driven one then zero by station
// - Report and accept suppressed preamble
// - Station leaves one idle bit between frames
`timescale 1ns/1ps
`include "phy_map.svh"
module phy_mac_side (
  input  logic       mclk,
  input  logic       rst,
  phy_link_if.phy    lnk,
  input  logic       line_rx_active,     // Receive activity on the wire
  input  logic       line_sq_valid,      // Squelch has qualified 10 Mb data
  input  logic       signal_detect_flag,
  input  logic       line_two_zeros,     // Pulse: two non-contiguous zeros
  input  logic       line_rx_vld,        // Pulse: recovered dibit present
  input  logic [1:0] line_rx_bits,
  input  logic [4:0] phy_addr,           // Strap, caught during reset
  output logic       line_tx_en,
  output logic       line_tx_vld,
  output logic [1:0] line_tx_bits
);
  // ****************************************************************
  // Configuration
  // ****************************************************************
  logic [15:0] ctrl_r;
  logic [1:0]  thr_r;
  logic        under_r, over_r;
  logic [4:0]  addr_r;
  logic        spd100, fdx, serial_network_if, hb;
  assign spd100 = ctrl_r[`CTRL_SPD];
  assign fdx    = ctrl_r[`CTRL_FDX];
  assign serial_network_if    = ctrl_r[`CTRL_SNI];
  assign hb     = ctrl_r[`CTRL_HB];

  // Strap capture is clocked, never a reset load of a port
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_r <= phy_addr;
    end
  end

  // ****************************************************************
  // Transfer cadence
  // ****************************************************************
  logic [3:0] div_r, div_lim;
  logic       tick;
  // Both ends reset together, so their dividers start in phase; cadence writes at different times leave them out of phase
  always_comb begin
    if (serial_network_if) begin
      div_lim = 4'(`SNI_DIV);
    end else if (spd100) begin
      div_lim = 4'h1;
    end else begin
      div_lim = 4'(`RMII_10M_DIV);
    end
  end
  assign tick = (div_r == div_lim - 4'h1);
  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Transmit sampling once per transfer slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      line_tx_en   <= 1'b0;
      line_tx_vld  <= 1'b0;
      line_tx_bits <= 2'h0;
    end else begin
      line_tx_vld <= tick & lnk.tx_en;
      if (tick) begin
        line_tx_en   <= lnk.tx_en;
        line_tx_bits <= serial_network_if ? {1'b0, lnk.txd[0]} : lnk.txd;
      end
    end
  end

  // ****************************************************************
  // Collision and heartbeat
  // ****************************************************************
  logic       col_raw, col_q, rx_lead_r, tx_prev_r, sqe_on;
  logic [4:0] col_cnt_r;
  logic [6:0] sqe_cnt_r;
  assign col_raw = !fdx & lnk.tx_en & line_rx_active;
  // Receive that led the collision needs no noise qualification
  always_ff @(posedge mclk) begin
    if (rst || !line_rx_active) begin
      rx_lead_r <= 1'b0;
    end else if (!lnk.tx_en) begin
      rx_lead_r <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst || !col_raw) begin
      col_cnt_r <= 5'h0;
    end else if (col_cnt_r != 5'(`COL_DLY_CYC)) begin
      col_cnt_r <= col_cnt_r + 5'h1;
    end
  end
  assign col_q = col_raw & (spd100 | rx_lead_r
                 | col_cnt_r == 5'(`COL_DLY_CYC));
  // Quality pulse timed from the fall of transmit enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_prev_r <= 1'b0;
      sqe_cnt_r <= 7'h0;
    end else begin
      tx_prev_r <= lnk.tx_en;
      if (tx_prev_r && !lnk.tx_en && hb && !spd100) begin
        sqe_cnt_r <= 7'h1;
      end else if (sqe_cnt_r == 7'(`SQE_END_CYC)) begin
        sqe_cnt_r <= 7'h0;
      end else if (sqe_cnt_r != 7'h0) begin
        sqe_cnt_r <= sqe_cnt_r + 7'h1;
      end
    end
  end
  assign sqe_on = (sqe_cnt_r > 7'(`SQE_GAP_CYC));

  // ****************************************************************
  // Carrier sense
  // ****************************************************************
  logic crs_rx_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      crs_rx_r <= 1'b0;
    end else if (!spd100) begin
      crs_rx_r <= line_sq_valid & line_rx_active;
    end else if (!line_rx_active || !signal_detect_flag) begin
      crs_rx_r <= 1'b0;
    end else if (line_two_zeros) begin
      crs_rx_r <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.crs <= 1'b0;
      lnk.col <= 1'b0;
    end else begin
      lnk.crs <= crs_rx_r | (!fdx & lnk.tx_en);
      lnk.col <= col_q | sqe_on;
    end
  end

  // ****************************************************************
  // Receive elasticity buffer
  // ****************************************************************
  phy_pkg::dibit_t eb_mem [0:`EB_DEPTH-1];
  logic [2:0] wp_r, rp_r;
  logic [3:0] cnt_r, thr_lvl;
  logic       run_r, bad_r, empty, full, push, pop, unf, ovf;
  // Threshold in dibits: 1,2,3 give 4,8,12 bits, 0 gives 16
  assign thr_lvl = (thr_r == 2'h0) ? 4'(`EB_DEPTH) : {1'b0, thr_r, 1'b0};
  assign empty = (cnt_r == 4'h0);
  assign full  = (cnt_r == 4'(`EB_DEPTH));
  assign pop   = tick & run_r & !empty;
  assign push  = line_rx_vld & line_rx_active & (!full | pop);
  assign ovf   = line_rx_vld & line_rx_active & full & !pop;
  assign unf   = tick & run_r & empty & line_rx_active;
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r  <= 3'h0;
      rp_r  <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      if (push) begin
        eb_mem[wp_r] <= line_rx_bits;
        wp_r         <= wp_r + 3'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 3'h1;
      end
      cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
    end
  end
  // Start draining at threshold, stop once the packet has emptied out
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      if (!run_r && line_rx_active && cnt_r >= thr_lvl) begin
        run_r <= 1'b1;
      end else if (run_r && !line_rx_active && empty) begin
        run_r <= 1'b0;
      end
      if (ovf || unf) begin
        bad_r <= 1'b1;
      end else if (!run_r && !line_rx_active) begin
        bad_r <= 1'b0;
      end
    end
  end
  // Inverted data breaks the frame check; cheaper than tracking the CRC
  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.rx_dv  <= 1'b0;
      lnk.rx_er  <= 1'b0;
      lnk.rxd    <= 2'h0;
      lnk.crs_dv <= 1'b0;
    end else begin
      lnk.crs_dv <= crs_rx_r | run_r;
      if (tick) begin
        lnk.rx_dv <= run_r & !(empty & !line_rx_active);
        lnk.rx_er <= run_r & (bad_r | unf);
        lnk.rxd   <= empty ? 2'h3 : eb_mem[rp_r] ^ {2{bad_r}};
      end
    end
  end

  // ****************************************************************
  // Management frame engine
  // ****************************************************************
  phy_pkg::mgmt_state_t st_r;
  logic        mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic        rise, fall, op_rd_r, hit_r;
  logic [3:0]  bcnt_r;
  logic [4:0]  ones_r, reg_r;
  logic [15:0] sh_r, rdsh_r, rd_val;
  logic [9:0]  addr10;
  logic        mg_wr, mg_clr;
  always_ff @(posedge mclk) begin
    if (rst) begin
      {mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2} <= 5'h0;
    end else begin
      mdc_s1  <= lnk.mdc;
      mdc_s2  <= mdc_s1;
      mdc_s3  <= mdc_s2;
      mdio_s1 <= lnk.mdio;
      mdio_s2 <= mdio_s1;
    end
  end
  assign rise   = mdc_s2 & !mdc_s3;
  assign fall   = !mdc_s2 & mdc_s3;
  assign addr10 = {sh_r[8:0], mdio_s2};
  assign mg_wr  = rise & (st_r == phy_pkg::MS_DATA) & (bcnt_r == 4'hF)
                  & !op_rd_r & hit_r;
  assign mg_clr = rise & (st_r == phy_pkg::MS_ADDR) & (bcnt_r == 4'h9) & op_rd_r
                  & (addr10[9:5] == addr_r) & (addr10[4:0] == `REG_RBR);
  always_comb begin
    case (addr10[4:0])
      `REG_CTRL: rd_val = ctrl_r;
      `REG_STAT: rd_val = (16'h1 << `STAT_PRE_SUP)
                          | ({15'h0, signal_detect_flag} << `STAT_LINK);
      `REG_RBR:  rd_val = {12'h0, over_r, under_r, thr_r};
      default:   rd_val = 16'h0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r    <= phy_pkg::MS_HUNT;
      bcnt_r  <= 4'h0;
      ones_r  <= 5'h0;
      op_rd_r <= 1'b0;
      hit_r   <= 1'b0;
      reg_r   <= 5'h0;
      sh_r    <= 16'h0;
      rdsh_r  <= 16'h0;
      lnk.phy_mdio_o  <= 1'b0;
      lnk.phy_mdio_oe <= 1'b0;
    end else if (rise) begin
      sh_r   <= {sh_r[14:0], mdio_s2};
      ones_r <= !mdio_s2 ? 5'h0 : (ones_r == 5'h1F) ? ones_r : ones_r + 5'h1;
      case (st_r)
        phy_pkg::MS_HUNT: if (mdio_s2 && ones_r == 5'(`PRE_BITS - 1)) begin
          st_r <= phy_pkg::MS_IDLE;
        end
        phy_pkg::MS_IDLE: if (!mdio_s2) begin
          st_r <= phy_pkg::MS_START;
        end
        phy_pkg::MS_START: begin
          st_r   <= mdio_s2 ? phy_pkg::MS_OP : phy_pkg::MS_HUNT;
          bcnt_r <= 4'h0;
        end
        phy_pkg::MS_OP: if (bcnt_r == 4'h0) begin
          bcnt_r <= 4'h1;
        end else begin
          op_rd_r <= sh_r[0];
          bcnt_r  <= 4'h0;
          st_r    <= (sh_r[0] != mdio_s2) ? phy_pkg::MS_ADDR : phy_pkg::MS_HUNT;
        end
        phy_pkg::MS_ADDR: if (bcnt_r == 4'h9) begin
          hit_r  <= (addr10[9:5] == addr_r);
          reg_r  <= addr10[4:0];
          rdsh_r <= rd_val;
          bcnt_r <= 4'h0;
          st_r   <= phy_pkg::MS_TA;
        end else begin
          bcnt_r <= bcnt_r + 4'h1;
        end
        phy_pkg::MS_TA: if (bcnt_r == 4'h0) begin
          bcnt_r <= 4'h1;
          if (!op_rd_r && !mdio_s2) st_r <= phy_pkg::MS_HUNT;
        end else begin
          bcnt_r <= 4'h0;
          st_r   <= (!op_rd_r && mdio_s2) ? phy_pkg::MS_HUNT : phy_pkg::MS_DATA;
        end
        phy_pkg::MS_DATA: if (bcnt_r == 4'hF) begin
          st_r <= phy_pkg::MS_IDLE;
        end else begin
          bcnt_r <= bcnt_r + 4'h1;
        end
        default: st_r <= phy_pkg::MS_HUNT;
      endcase
      if (st_r != phy_pkg::MS_HUNT && st_r != phy_pkg::MS_IDLE && st_r != phy_pkg::MS_DATA
          && st_r != phy_pkg::MS_ADDR && st_r != phy_pkg::MS_OP && !mdio_s2
          && st_r == phy_pkg::MS_START) begin
        ones_r <= 5'h0;
      end
    end else if (fall) begin
      // Drive only on the falling edge, so the station samples a stable line
      if (st_r == phy_pkg::MS_TA && bcnt_r == 4'h1 && op_rd_r && hit_r) begin
        lnk.phy_mdio_oe <= 1'b1;
        lnk.phy_mdio_o  <= 1'b0;
      end else if (st_r == phy_pkg::MS_DATA && op_rd_r && hit_r) begin
        lnk.phy_mdio_oe <= 1'b1;
        lnk.phy_mdio_o  <= rdsh_r[15];
        rdsh_r          <= {rdsh_r[14:0], 1'b0};
      end else begin
        lnk.phy_mdio_oe <= 1'b0;
        lnk.phy_mdio_o  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register file behind the management port
  // ****************************************************************
  // Slip flags are sticky; a new slip wins over the clear-on-read
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r  <= `CTRL_RST;
      thr_r   <= `RBR_RST;
      under_r <= 1'b0;
      over_r  <= 1'b0;
    end else begin
      if (mg_wr && reg_r == `REG_CTRL) ctrl_r <= {sh_r[14:0], mdio_s2};
      if (mg_wr && reg_r == `REG_RBR) thr_r <= {sh_r[0], mdio_s2};
      under_r <= unf | (under_r & !mg_clr);
      over_r  <= ovf | (over_r & !mg_clr);
    end
  end
endmodule

/* hw/phy_map.svh */
// Offsets, field positions, reset values and timing counts of the PHY link.
// Assumes inclusion by bare name from the design files.
`ifndef PHY_MAP_SVH
`define PHY_MAP_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS         25
`define BIT_NS         100
`define BIT_CYC        ((`BIT_NS + `CLK_NS - 1) / `CLK_NS)
`define COL_DLY_BITS   7
`define COL_DLY_CYC    (`COL_DLY_BITS * `BIT_CYC)
`define SQE_GAP_NS     1000
`define SQE_GAP_CYC    (`SQE_GAP_NS / `CLK_NS)
`define SQE_LEN_BITS   10
`define SQE_END_CYC    (`SQE_GAP_CYC + `SQE_LEN_BITS * `BIT_CYC)
`define RMII_10M_DIV   10
`define SNI_NS         100
`define SNI_DIV        (`SNI_NS / `CLK_NS)
`define MDC_HALF       10
`define PRE_BITS       32
`define EB_DEPTH       8
// ****************************************************************
// Device management registers
// ****************************************************************
`define REG_CTRL       5'h00
`define REG_STAT       5'h01
`define REG_RBR        5'h10
`define CTRL_RST       16'h2000
`define CTRL_SPD       13
`define CTRL_FDX       8
`define CTRL_SNI       1
`define CTRL_HB        0
`define STAT_PRE_SUP   6
`define STAT_LINK      2
`define RBR_RST        2'h1
`define RBR_UNDER      2
`define RBR_OVER       3
// ****************************************************************
// Station registers
// ****************************************************************
`define SA_CMD         3'h0
`define SA_WDATA       3'h1
`define SA_RDATA       3'h2
`define SA_STAT        3'h3
`define SA_CFG         3'h4
`define CMD_GO         15
`define CMD_RD         14
`define CMD_NOPRE      13
`define CFG_RST        16'h0001
`endif

/* hw/phy_pkg.sv */
// Types of the PHY link; the dibit type is shared by both ends, the management states by the PHY end only.
// Assumes nothing beyond a SystemVerilog compiler.
package phy_pkg;
  typedef enum logic [2:0] {MS_HUNT, MS_IDLE, MS_START, MS_OP, MS_ADDR, MS_TA,
                            MS_DATA} mgmt_state_t;
  typedef logic [1:0] dibit_t;
endpackage

/* hw/phy_link_if.sv */
// Pins between the PHY end and the MAC/station end.
// Assumes both ends run on one mclk; MDIO level is resolved here with pull-up.
`timescale 1ns/1ps
interface phy_link_if;
  logic          tx_en;
  phy_pkg::dibit_t txd;
  logic          crs_dv;
  logic          rx_dv;
  logic          rx_er;
  phy_pkg::dibit_t rxd;
  logic          crs;
  logic          col;
  logic          mdc;
  logic          sta_mdio_o;
  logic          sta_mdio_oe;
  logic          phy_mdio_o;
  logic          phy_mdio_oe;
  logic          mdio;
  // Pull-up: an undriven line reads one
  assign mdio = (!sta_mdio_oe | sta_mdio_o) & (!phy_mdio_oe | phy_mdio_o);
  modport phy (input tx_en, txd, mdc, mdio,
               output crs_dv, rx_dv, rx_er, rxd, crs, col, phy_mdio_o, phy_mdio_oe);
  modport mac (input crs_dv, rx_dv, rx_er, rxd, crs, col, mdio,
               output tx_en, txd, mdc, sta_mdio_o, sta_mdio_oe);
endinterface

/* hw/mac_station_end.sv */
// MAC and station end: data at the shared cadence, management frames out.
// Assumes the PHY end shares mclk and reset; software uses a plain port.
`timescale 1ns/1ps
`include "phy_map.svh"
module mac_station_end (
  input  logic        mclk,
  input  logic        rst,
  phy_link_if.mac     lnk,
  input  logic [2:0]  addr,
  input  logic [15:0] wdata,
  input  logic        wr,
  input  logic        rd,
  output logic [15:0] rdata,
  input  logic        tx_valid,
  input  logic [1:0]  tx_bits,
  output logic        tx_ready,
  output logic        rx_vld,
  output logic [1:0]  rx_bits,
  output logic        rx_err,
  output logic        crs,
  output logic        col
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] cfg_r, wdat_r, rdat_r;
  logic        busy_r, done_r, inited_r, start, fin;
  assign start = wr & (addr == `SA_CMD) & wdata[`CMD_GO] & !busy_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r  <= `CFG_RST;
      wdat_r <= 16'h0;
      done_r <= 1'b0;
      rdata  <= 16'h0;
    end else begin
      if (wr && addr == `SA_CFG) cfg_r <= wdata;
      if (wr && addr == `SA_WDATA) wdat_r <= wdata;
      done_r <= fin | (done_r & !(rd && addr == `SA_STAT));
      case (rd ? addr : 3'h7)
        `SA_WDATA: rdata <= wdat_r;
        `SA_RDATA: rdata <= rdat_r;
        `SA_STAT:  rdata <= {13'h0, inited_r, done_r, busy_r};
        `SA_CFG:   rdata <= cfg_r;
        default:   rdata <= 16'h0;
      endcase
    end
  end

  // ****************************************************************
  // Data cadence
  // ****************************************************************
  logic [3:0] div_r, div_lim;
  always_comb begin
    if (cfg_r[1]) begin
      div_lim = 4'(`SNI_DIV);
    end else if (cfg_r[0]) begin
      div_lim = 4'h1;
    end else begin
      div_lim = 4'(`RMII_10M_DIV);
    end
  end
  assign tx_ready = (div_r == div_lim - 4'h1);
  always_ff @(posedge mclk) begin
    if (rst || tx_ready) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  // Transmit and receive move one transfer per slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.tx_en <= 1'b0;
      lnk.txd   <= 2'h0;
      rx_vld    <= 1'b0;
      rx_bits   <= 2'h0;
      rx_err    <= 1'b0;
      crs       <= 1'b0;
      col       <= 1'b0;
    end else begin
      crs    <= lnk.crs;
      col    <= lnk.col;
      rx_vld <= tx_ready & lnk.rx_dv;
      if (tx_ready) begin
        lnk.tx_en <= tx_valid;
        lnk.txd   <= tx_bits;
        rx_bits   <= lnk.rxd;
        rx_err    <= lnk.rx_er;
      end
    end
  end

  // ****************************************************************
  // Management frame generator
  // ****************************************************************
  logic [31:0] frm_r;
  logic [6:0]  cur_r, fidx;
  logic [3:0]  mcnt_r;
  logic        op_rd_r, evt, mdio_s1, mdio_s2, bit_val;
  assign evt  = busy_r & (mcnt_r == 4'(`MDC_HALF - 1));
  assign fin  = evt & lnk.mdc & (cur_r == 7'd64);
  assign fidx = 7'd63 - cur_r;
  assign bit_val = (cur_r < 7'd32) | (cur_r > 7'd63) | frm_r[fidx[4:0]];
  always_ff @(posedge mclk) begin
    if (rst) begin
      {mdio_s1, mdio_s2} <= 2'h0;
    end else begin
      mdio_s1 <= lnk.mdio;
      mdio_s2 <= mdio_s1;
    end
  end
  // Slow divider keeps the clock far under its ceiling, leaving sync margin
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_r   <= 1'b0;
      inited_r <= 1'b0;
      op_rd_r  <= 1'b0;
      frm_r    <= 32'h0;
      cur_r    <= 7'h0;
      mcnt_r   <= 4'h0;
      rdat_r   <= 16'h0;
      lnk.mdc  <= 1'b0;
    end else if (start) begin
      busy_r  <= 1'b1;
      op_rd_r <= wdata[`CMD_RD];
      frm_r   <= {2'b01, wdata[`CMD_RD] ? 2'b10 : 2'b01, wdata[9:0],
                  2'b10, wdat_r};
      cur_r   <= (wdata[`CMD_NOPRE] && inited_r) ? 7'd32 : 7'd0;
      mcnt_r  <= 4'h0;
    end else if (evt) begin
      mcnt_r  <= 4'h0;
      lnk.mdc <= !lnk.mdc;
      // The idle bit after the data must not shift into the read word
      if (!lnk.mdc && op_rd_r && cur_r > 7'd47 && cur_r < 7'd64) begin
        rdat_r <= {rdat_r[14:0], mdio_s2};
      end
      if (lnk.mdc) begin
        cur_r <= cur_r + 7'h1;
        if (cur_r == 7'd64) begin
          busy_r   <= 1'b0;
          inited_r <= 1'b1;
        end
      end
    end else if (busy_r) begin
      mcnt_r <= mcnt_r + 4'h1;
    end
  end
  // Release the line for the read turnaround and data
  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.sta_mdio_o  <= 1'b1;
      lnk.sta_mdio_oe <= 1'b0;
    end else begin
      lnk.sta_mdio_o  <= bit_val;
      lnk.sta_mdio_oe <= busy_r & (cur_r < 7'd64) & (!op_rd_r | cur_r < 7'd46);
    end
  end
endmodule

/* test/phy_link_checker.sv */
// Checker on the link pins between the two ends.
// Assumes one mclk domain and synchronous active-high rst.
`timescale 1ns/1ps
module phy_link_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_en,
  input wire logic crs_dv,
  input wire logic rx_dv,
  input wire logic col,
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic phy_mdio_o,
  input wire logic phy_mdio_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************************************
  // Cycles since transmit; heartbeat may trail it
  // ****************************************
  logic [7:0] since_tx_r;
  always_ff @(posedge mclk) begin
    if (rst || tx_en) since_tx_r <= 8'h00;
    else if (since_tx_r != 8'hFF) since_tx_r <= since_tx_r + 8'h01;
  end
  property p_no_fight; !(sta_mdio_oe && phy_mdio_oe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("mdio contention");
  property p_ta_zero; $rose(phy_mdio_oe) |-> !phy_mdio_o; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_phy_move; phy_mdio_oe && $changed(phy_mdio_o) |-> !mdc; endproperty
  a_phy_move: assert property (p_phy_move) else $error("phy moved mdio high");
  property p_sta_move; sta_mdio_oe && $changed(sta_mdio_o) |-> !mdc; endproperty
  a_sta_move: assert property (p_sta_move) else $error("sta moved mdio high");
  property p_mdc_hi; $rose(mdc) |-> mdc [*8]; endproperty
  a_mdc_hi: assert property (p_mdc_hi) else $error("mdc high too short");
  property p_mdc_lo; $fell(mdc) |-> !mdc [*8]; endproperty
  a_mdc_lo: assert property (p_mdc_lo) else $error("mdc low too short");
  property p_rx_dv; rx_dv |-> crs_dv; endproperty
  a_rx_dv: assert property (p_rx_dv) else $error("rx_dv without crs_dv");
  property p_col_tx; col |-> since_tx_r < 8'h5A; endproperty
  a_col_tx: assert property (p_col_tx) else $error("col without transmit");
  property p_quiet; $fell(rst) |-> !phy_mdio_oe [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("phy drove mdio early");
endmodule

/* test/tb.sv */
// Bench joining both ends; drives software port, tx stream and line side.
// Assumes the map header and interface are compiled first.
`timescale 1ns/1ps
`include "phy_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module tb;
  logic mclk, rst, wr, rd, tx_valid, tx_ready, rx_vld, rx_err, crs, col, rd_q;
  logic line_rx_active, line_sq_valid, signal_detect_flag, line_two_zeros;
  logic line_rx_vld, line_tx_en, line_tx_vld;
  logic [1:0] tx_bits, rx_bits, line_rx_bits, line_tx_bits;
  logic [2:0] addr;
  logic [15:0] wdata, rdata, ev;
  logic [4:0] phy_addr;
  int n_errors = 0, checks = 0;
  logic [15:0] rq[$];
  logic [1:0] txq[$], rxq[$];
  phy_link_if phy_link_if_inst ();
  phy_mac_side phy_mac_side_inst (.mclk, .rst, .lnk(phy_link_if_inst), .line_rx_active,
    .line_sq_valid, .signal_detect_flag, .line_two_zeros, .line_rx_vld, .line_rx_bits,
    .phy_addr, .line_tx_en, .line_tx_vld, .line_tx_bits);
  mac_station_end mac_station_end_inst (.mclk, .rst, .lnk(phy_link_if_inst), .addr, .wdata,
    .wr, .rd, .rdata, .tx_valid, .tx_bits, .tx_ready, .rx_vld, .rx_bits, .rx_err, .crs, .col);
  phy_link_checker phy_link_checker_inst (.mclk, .rst, .tx_en(phy_link_if_inst.tx_en),
    .crs_dv(phy_link_if_inst.crs_dv), .rx_dv(phy_link_if_inst.rx_dv),
    .col(phy_link_if_inst.col), .mdc(phy_link_if_inst.mdc),
    .sta_mdio_o(phy_link_if_inst.sta_mdio_o), .sta_mdio_oe(phy_link_if_inst.sta_mdio_oe),
    .phy_mdio_o(phy_link_if_inst.phy_mdio_o), .phy_mdio_oe(phy_link_if_inst.phy_mdio_oe));
  // ****************************************
  // Clock, monitors and tasks
  // ****************************************
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  // Results are popped in order; a pop on empty gives X and fails
  always @(posedge mclk) begin
    rd_q <= rd && addr == `SA_RDATA;
    if (rd_q) begin ev = rq.pop_front(); `CHK(rdata, ev) end
    if (line_tx_vld) begin ev = txq.pop_front(); `CHK(line_tx_bits, ev[1:0]) end
    if (rx_vld) begin ev = rxq.pop_front(); `CHK(rx_bits, ev[1:0]) end
  end
  task bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= w; rd <= !w;
    @(posedge mclk); wr <= 0; rd <= 0;
  endtask
  // Op bit1 reads (d is then the expected word), bit0 skips preamble
  task mgmt(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] d);
    bus(1, `SA_WDATA, d);
    bus(1, `SA_CMD, {1'b1, op, 3'h0, pa, ra});
    repeat (1000) begin bus(0, `SA_STAT, 16'h0000); #1; if (rdata[1]) break; end
    if (op[1]) begin rq.push_back(d); bus(0, `SA_RDATA, 16'h0000); end
  endtask
  task burst(input int n);
    repeat (n + 1) begin
      @(posedge mclk);
      if (tx_valid && tx_ready) txq.push_back(tx_bits);
      tx_valid <= n > 0; tx_bits <= $urandom; n--;
    end
  endtask
  task coll(input logic c, input logic s);
    fork
      burst(30);
      begin
        // Late enough that transmit leads even at the slow cadence
        repeat (12) @(posedge mclk); line_rx_active <= 1;
        repeat (12) @(posedge mclk);
        `CHK(col, c)
        `CHK(crs, s)
        line_rx_active <= 0;
      end
    join
  endtask
  task rx_pkt(input int n);
    logic [1:0] b;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk); b = $urandom; rxq.push_back(b);
      line_rx_active <= 1; line_two_zeros <= i == 0; line_rx_vld <= 1; line_rx_bits <= b;
    end
    @(posedge mclk); line_rx_vld <= 0; line_rx_active <= 0;
    `CHK(crs, 1'b1)
    repeat (40) @(posedge mclk);
    `CHK(crs, 1'b0)
    `CHK(rx_err, 1'b0)
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Frames take about 1300 cycles each, 660 without preamble, so 60000 is ample
  initial begin repeat (60000) @(posedge mclk); n_errors++; wrap_up(); end
  initial begin
    {addr, wdata, wr, rd, tx_valid, tx_bits, line_rx_vld, line_rx_bits} = '0;
    {line_rx_active, line_two_zeros} = '0;
    {line_sq_valid, signal_detect_flag, rst, rd_q} = 4'hE; phy_addr = 5'h05;
    void'($urandom(31794));
    repeat (12) @(posedge mclk); rst <= 0;
    mgmt(2'b10, 5'h05, `REG_CTRL, `CTRL_RST);
    mgmt(2'b10, 5'h05, `REG_STAT, 16'h0044);
    mgmt(2'b10, 5'h06, `REG_CTRL, 16'hFFFF);
    mgmt(2'b10, 5'h05, `REG_RBR, 16'h0001);
    $display("management test done");
    coll(1, 1);
    mgmt(2'b00, 5'h05, `REG_CTRL, 16'h0001);
    bus(1, `SA_CFG, 16'h0000);
    coll(0, 1);
    ev = 0;
    repeat (150) begin @(posedge mclk); ev |= col; end
    `CHK(ev[0], 1'b1)
    bus(1, `SA_CFG, 16'h0001);
    mgmt(2'b00, 5'h05, `REG_CTRL, 16'h2100);
    mgmt(2'b11, 5'h05, `REG_CTRL, 16'h2100);
    coll(0, 0);
    $display("duplex test done");
    rx_pkt(24);
    mgmt(2'b00, 5'h05, `REG_RBR, 16'h0003);
    rx_pkt(24);
    $display("receive test done");
    wrap_up();
  end
endmodule
